// ### rtl/ipl_pkg.sv
// Constants shared by the prioritized interrupt latch controller
package ipl_pkg;
  localparam int NUM_SRC = 32;
  localparam int SRC_W = 5;
  localparam int NUM_BYTES = 4;
  localparam logic [SRC_W-1:0] SRC_FETCH_TRAP = 5'h02;
  localparam logic [SRC_W-1:0] SRC_WATCHDOG = 5'h03;
  localparam logic [SRC_W-1:0] SRC_FIRST_MASKABLE = 5'h04;
  localparam logic [SRC_W-1:0] SRC_EXT_ZERO = 5'h06;
  localparam logic [SRC_W-1:0] SRC_SPLIT = 5'h10;
  localparam logic [NUM_SRC-1:0] NMI_MASK = 32'h0000_000c;
  localparam logic [NUM_SRC-1:0] EF_IMPL_MASK = 32'hffff_fff0;
  localparam logic [7:0] ADDR_PEND_E = 8'h2e;
  localparam logic [7:0] ADDR_PEND_F = 8'h2f;
  localparam logic [7:0] ADDR_PEND_LOW = 8'h3c;
  localparam logic [7:0] ADDR_PEND_HIGH = 8'h3d;
  localparam logic [7:0] ADDR_EN_E = 8'h2c;
  localparam logic [7:0] ADDR_EN_D = 8'h2d;
  localparam logic [7:0] ADDR_ENABLE_LOW_REG = 8'h3a;
  localparam logic [7:0] ADDR_EN_HIGH = 8'h3b;
  localparam int MASTER_ENABLE_BIT = 0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] PEND_RESET = 8'h00;
  localparam logic [NUM_SRC-1:0] EF_RESET = 32'h0000_0000;
  localparam logic MASTER_ENABLE_RESET = 1'b0;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_BASE_LOW = 16'hfffe;
  localparam logic [15:0] VEC_BASE_HIGH = 16'hffde;

  function automatic logic [15:0] ipl_vector_type_of(input logic [SRC_W-1:0] n);
    logic [15:0] step;
    step = {10'h000, n, 1'b0};
    if (n < SRC_SPLIT) begin
      return 16'(VEC_BASE_LOW - step);
    end
    return 16'(VEC_BASE_HIGH - step);
  endfunction
endpackage

// ### rtl/ipl_arb_if.sv
// Carrier between the controller and its priority arbiter
`timescale 1ns/10ps
interface ipl_arb_if;
  logic [ipl_pkg::NUM_SRC-1:0] eligible;
  logic found;
  logic [ipl_pkg::SRC_W-1:0] idx;
  modport requester(output eligible, input found, input idx);
  modport arbiter(input eligible, output found, output idx);
endinterface

// ### rtl/ipl_latch_byte.sv
// One byte of pending latches: hardware set, write-zero clear, accept clear
`timescale 1ns/10ps
module ipl_latch_byte
  import ipl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Updates
  input wire logic [7:0] i_set,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_ack_clr,
  // State
  output logic [7:0] o_q,
  output logic [7:0] o_next_q
);
  logic [7:0] clr;

  always_comb begin
    clr = (i_wr ? ~i_wdata : BYTE_ZERO) | i_ack_clr;
    o_next_q = (o_q & ~clr) | i_set;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_q <= PEND_RESET;
    end else begin
      o_q <= o_next_q;
    end
  end

  a_set_latches: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (|i_set) |=> ((o_q & $past(i_set)) == $past(i_set)))
    else $error("requested latch did not become pending");
  a_write_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wr && i_set == BYTE_ZERO && i_ack_clr == BYTE_ZERO) |=> (o_q == ($past(o_q) & $past(i_wdata))))
    else $error("write did not clear exactly the zero bits");
endmodule // ipl_latch_byte

// ### rtl/ipl_prio_arb.sv
// Fixed-priority pick of the lowest numbered eligible source
`timescale 1ns/10ps
module ipl_prio_arb
  import ipl_pkg::*;
(
  // Clock and reset, used by the checks only
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Candidates and pick
  ipl_arb_if.arbiter arb
);
  always_comb begin
    arb.found = 1'b0;
    arb.idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (arb.eligible[i]) begin
        arb.found = 1'b1;
        arb.idx = SRC_W'(i);
      end
    end
  end

  a_lowest_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    arb.found |-> (arb.eligible[arb.idx]
      && (arb.eligible & ((NUM_SRC'(1) << arb.idx) - NUM_SRC'(1))) == '0))
    else $error("arbiter did not pick the lowest eligible source");
endmodule // ipl_prio_arb

// ### rtl/ipl_irq_ctrl.sv
// Prioritized interrupt latch controller: latches, enables and vector offer
`timescale 1ns/10ps

module ipl_irq_ctrl
  import ipl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Special-function register access
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Request sources
  input wire logic [NUM_SRC-1:SRC_FIRST_MASKABLE] i_maskable_req,
  input wire logic i_fetch_trap_event,
  input wire logic i_watchdog_event,
  input wire logic i_soft_trap_event,
  input wire logic i_bad_opcode_event,
  // Source configuration held elsewhere
  input wire logic i_fetch_trap_action_sel,
  input wire logic i_watchdog_action_sel,
  input wire logic i_ext_zero_pin_enable,
  // CPU accept sequence
  input wire logic i_irq_accept,
  input wire logic i_return_from_irq,
  input wire logic i_stacked_master_enable,
  output logic o_irq_req,
  output logic [SRC_W-1:0] o_irq_source,
  output logic [15:0] o_irq_vector,
  output logic o_trap_taken,
  output logic o_stacked_master_enable,
  output logic o_master_enable_flag,
  output logic o_reset_req
);
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] next_pending;
  logic [NUM_SRC-1:0] set_all;
  logic [NUM_SRC-1:0] ack_clr;
  logic [NUM_SRC-1:0] source_enable_flag;
  logic [NUM_SRC-1:0] next_source_enable_flag;
  logic [NUM_SRC-1:0] accept_mask;
  logic [NUM_BYTES-1:0] pend_wr;
  logic next_master_enable_flag;
  logic fetch_trap_irq;
  logic watchdog_irq;
  logic trap_now;
  logic accept_now;
  logic [7:0] rd_value;

  // Candidates go out and the pick comes back on one carrier
  ipl_arb_if arb_bus();

  // Selector high means the event goes out as a reset, not as a latch
  assign fetch_trap_irq = i_fetch_trap_event && !i_fetch_trap_action_sel;
  assign watchdog_irq = i_watchdog_event && !i_watchdog_action_sel;

  always_comb begin
    set_all = '0;
    set_all[NUM_SRC-1:SRC_FIRST_MASKABLE] = i_maskable_req;
    set_all[SRC_FETCH_TRAP] = fetch_trap_irq;
    set_all[SRC_WATCHDOG] = watchdog_irq;
  end

  // No latch for these two; they are taken the moment they occur
  assign trap_now = i_soft_trap_event || i_bad_opcode_event;
  // An accept with no offer standing is ignored
  assign accept_now = i_irq_accept && o_irq_req;
  assign ack_clr = accept_now ? (NUM_SRC'(1) << o_irq_source) : '0;

  // One write strobe per latch byte
  always_comb begin
    pend_wr[0] = i_sfr_wr && (i_sfr_addr == ADDR_PEND_LOW);
    pend_wr[1] = i_sfr_wr && (i_sfr_addr == ADDR_PEND_HIGH);
    pend_wr[2] = i_sfr_wr && (i_sfr_addr == ADDR_PEND_E);
    pend_wr[3] = i_sfr_wr && (i_sfr_addr == ADDR_PEND_F);
  end

  for (genvar k = 0; k < NUM_BYTES; k++) begin : g_pend
    ipl_latch_byte u_byte (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_set(set_all[8*k +: 8]),
      .i_wr(pend_wr[k]),
      .i_wdata(i_sfr_wdata),
      .i_ack_clr(ack_clr[8*k +: 8]),
      .o_q(pending[8*k +: 8]),
      .o_next_q(next_pending[8*k +: 8])
    );
  end

  // Enable flags: reserved low bits never hold a one
  always_comb begin
    next_source_enable_flag = source_enable_flag;
    if (i_sfr_wr && i_sfr_addr == ADDR_ENABLE_LOW_REG) begin
      next_source_enable_flag[7:0] = i_sfr_wdata;
    end else if (i_sfr_wr && i_sfr_addr == ADDR_EN_HIGH) begin
      next_source_enable_flag[15:8] = i_sfr_wdata;
    end else if (i_sfr_wr && i_sfr_addr == ADDR_EN_E) begin
      next_source_enable_flag[23:16] = i_sfr_wdata;
    end else if (i_sfr_wr && i_sfr_addr == ADDR_EN_D) begin
      next_source_enable_flag[31:24] = i_sfr_wdata;
    end
    next_source_enable_flag = next_source_enable_flag & EF_IMPL_MASK;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      source_enable_flag <= EF_RESET;
    end else begin
      source_enable_flag <= next_source_enable_flag;
    end
  end

  // Acceptance outranks a return, which outranks a plain write
  always_comb begin
    if (trap_now || accept_now) begin
      next_master_enable_flag = 1'b0;
    end else if (i_return_from_irq) begin
      next_master_enable_flag = i_stacked_master_enable;
    end else if (i_sfr_wr && i_sfr_addr == ADDR_ENABLE_LOW_REG) begin
      next_master_enable_flag = i_sfr_wdata[MASTER_ENABLE_BIT];
    end else begin
      next_master_enable_flag = o_master_enable_flag;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_master_enable_flag <= MASTER_ENABLE_RESET;
    end else begin
      o_master_enable_flag <= next_master_enable_flag;
    end
  end

  // The value stacked by the CPU on acceptance
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_stacked_master_enable <= MASTER_ENABLE_RESET;
    end else if (trap_now || accept_now) begin
      o_stacked_master_enable <= o_master_enable_flag;
    end
  end

  // Non-maskable latches ignore the master enable, so they nest anywhere
  always_comb begin
    accept_mask = next_source_enable_flag & {NUM_SRC{next_master_enable_flag}};
    accept_mask[SRC_EXT_ZERO] = accept_mask[SRC_EXT_ZERO] && i_ext_zero_pin_enable;
    accept_mask = accept_mask | NMI_MASK;
  end

  // Judged on next-state values so an accepted source is never re-offered
  assign arb_bus.eligible = next_pending & accept_mask;

  // Lowest index wins; the two trap latches tie in rank, so the index decides
  ipl_prio_arb u_arb (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .arb(arb_bus)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_req <= 1'b0;
      o_irq_source <= '0;
      o_irq_vector <= VEC_RESET;
      o_trap_taken <= 1'b0;
    end else begin
      // Offer drops for the trap cycle; the CPU is busy taking the trap
      o_irq_req <= arb_bus.found && !trap_now;
      o_irq_source <= arb_bus.idx;
      o_trap_taken <= trap_now;
      if (trap_now) begin
        o_irq_vector <= VEC_TRAP;
      end else begin
        o_irq_vector <= ipl_vector_type_of(arb_bus.idx);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reset_req <= 1'b0;
    end else begin
      // Reset route leaves the latches untouched
      o_reset_req <= (i_fetch_trap_event && i_fetch_trap_action_sel)
        || (i_watchdog_event && i_watchdog_action_sel);
    end
  end

  // Reads show live latch and enable state; unmapped bytes read zero
  always_comb begin
    if (i_sfr_addr == ADDR_PEND_LOW) begin
      rd_value = pending[7:0];
    end else if (i_sfr_addr == ADDR_PEND_HIGH) begin
      rd_value = pending[15:8];
    end else if (i_sfr_addr == ADDR_PEND_E) begin
      rd_value = pending[23:16];
    end else if (i_sfr_addr == ADDR_PEND_F) begin
      rd_value = pending[31:24];
    end else if (i_sfr_addr == ADDR_ENABLE_LOW_REG) begin
      rd_value = source_enable_flag[7:0] | {7'h00, o_master_enable_flag};
    end else if (i_sfr_addr == ADDR_EN_HIGH) begin
      rd_value = source_enable_flag[15:8];
    end else if (i_sfr_addr == ADDR_EN_E) begin
      rd_value = source_enable_flag[23:16];
    end else if (i_sfr_addr == ADDR_EN_D) begin
      rd_value = source_enable_flag[31:24];
    end else begin
      rd_value = BYTE_ZERO;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= BYTE_ZERO;
    end else if (i_sfr_rd) begin
      // Held until the next read so a slow fetch still sees it
      o_sfr_rdata <= rd_value;
    end
  end

  a_accept_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (accept_now && set_all[o_irq_source] == 1'b0)
      |=> pending[$past(o_irq_source)] == 1'b0)
    else $error("accepted latch was not cleared");
  a_no_write_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (set_all == '0) |=> (pending & ~$past(pending)) == '0)
    else $error("latch rose without a hardware request");
  a_enable_saved: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (accept_now || trap_now) |=> (!o_master_enable_flag
      && o_stacked_master_enable == $past(o_master_enable_flag)))
    else $error("master enable not saved and cleared on acceptance");
  a_mask_gates: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_irq_req && o_irq_source >= SRC_FIRST_MASKABLE)
      |-> (o_master_enable_flag && source_enable_flag[o_irq_source]))
    else $error("maskable source offered while disabled");
  a_pin_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_irq_req && o_irq_source == SRC_EXT_ZERO) |-> $past(i_ext_zero_pin_enable))
    else $error("external input zero offered without pin enable");
  a_vector_map: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_irq_req |-> o_irq_vector == ipl_vector_type_of(o_irq_source))
    else $error("vector does not match offered source");
  a_nmi_offered: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (watchdog_irq && !i_soft_trap_event && !i_bad_opcode_event && !i_fetch_trap_event
      && (pending[SRC_WATCHDOG - 1'b1] == 1'b0)) |=> o_irq_req && o_irq_source <= SRC_WATCHDOG)
    else $error("watchdog interrupt not offered next cycle");
  a_trap_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_fetch_trap_event && i_fetch_trap_action_sel)
      |=> o_reset_req ##0 ($past(pending[SRC_FETCH_TRAP]) || !pending[SRC_FETCH_TRAP]))
    else $error("fetch trap with reset action misrouted");

  // Trap sequencing and the reset route
  a_trap_vector: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    trap_now |=> (o_trap_taken && !o_irq_req && o_irq_vector == VEC_TRAP))
    else $error("trap did not offer the shared trap vector");
  a_trap_no_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (trap_now && set_all == '0 && pend_wr == '0 && !accept_now)
      |=> pending == $past(pending))
    else $error("trap disturbed the pending latches");
  a_trap_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_trap_taken |-> $past(trap_now))
    else $error("trap pulse without a trap");
  a_reset_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_fetch_trap_event && !i_watchdog_event) |=> !o_reset_req)
    else $error("reset request without an event");
  a_watchdog_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_watchdog_event && i_watchdog_action_sel)
      |=> (o_reset_req && ($past(pending[SRC_WATCHDOG]) || !pending[SRC_WATCHDOG])))
    else $error("watchdog with reset action misrouted");

  // Non-maskable latches and the offer
  a_fetch_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fetch_trap_irq |=> pending[SRC_FETCH_TRAP])
    else $error("fetch trap interrupt not latched");
  a_watchdog_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    watchdog_irq |=> pending[SRC_WATCHDOG])
    else $error("watchdog interrupt not latched");
  a_nmi_unmasked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ((next_pending & NMI_MASK) != '0 && !trap_now)
      |=> (o_irq_req && o_irq_source <= SRC_WATCHDOG))
    else $error("pending non-maskable source not offered");
  a_offer_pending: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_irq_req |-> pending[o_irq_source])
    else $error("offered source has no pending latch");

  // Master enable and register reads
  a_return_restores: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_return_from_irq && !trap_now && !accept_now)
      |=> o_master_enable_flag == $past(i_stacked_master_enable))
    else $error("return did not restore the master enable");
  a_enable_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_sfr_wr && i_sfr_addr == ADDR_ENABLE_LOW_REG && !trap_now && !accept_now && !i_return_from_irq)
      |=> o_master_enable_flag == $past(i_sfr_wdata[MASTER_ENABLE_BIT]))
    else $error("master enable write not taken");
  a_pend_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_sfr_rd && i_sfr_addr == ADDR_PEND_LOW)
      |=> o_sfr_rdata == $past(pending[7:0]))
    else $error("latch byte read does not show live state");
  a_rdata_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data changed without a read");

  c_accept: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    accept_now ##1 o_irq_req);
  c_trap: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_trap_taken && o_stacked_master_enable);
  c_nmi_nested: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_irq_req && !o_master_enable_flag && o_irq_source == SRC_FETCH_TRAP);
  c_write_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    (|pend_wr) && (pending != '0) ##1 (pending != $past(pending)));
  c_high_range: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_irq_req && o_irq_source >= SRC_SPLIT);
endmodule // ipl_irq_ctrl

// ### sim/ipl_cpu_model.sv
// CPU sequencer model: accepts offered interrupts and returns from them later
`timescale 1ns/10ps
module ipl_cpu_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control from the bench
  input wire logic i_go,
  input wire logic [1:0] i_wait,
  // Controller side
  input wire logic i_irq_req,
  input wire logic i_stacked_master_enable,
  output logic o_irq_accept,
  output logic o_return_from_irq,
  output logic o_stacked_master_enable
);
  logic [1:0] state;
  logic [2:0] cnt;
  logic stk;

  // Outside the return pulse the popped value is not meaningful, so show its inverse
  assign o_stacked_master_enable = o_return_from_irq ? stk : ~stk;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= 2'h0;
      cnt <= 3'h0;
      stk <= 1'b0;
      o_irq_accept <= 1'b0;
      o_return_from_irq <= 1'b0;
    end else begin
      o_irq_accept <= 1'b0;
      o_return_from_irq <= 1'b0;
      case (state)
        2'h0: begin
          if (i_go && i_irq_req) begin
            cnt <= {1'b0, i_wait};
            state <= 2'h1;
          end
        end
        2'h1: begin
          // Accept only while the offer still stands
          if (!i_irq_req) begin
            state <= 2'h0;
          end else if (cnt == 3'h0) begin
            o_irq_accept <= 1'b1;
            cnt <= 3'h4;
            state <= 2'h2;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        2'h2: begin
          if (cnt == 3'h3) begin
            stk <= i_stacked_master_enable;
          end
          if (cnt == 3'h0) begin
            o_return_from_irq <= 1'b1;
            state <= 2'h3;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        default: begin
          state <= 2'h0;
        end
      endcase
    end
  end
endmodule // ipl_cpu_model

// ### sim/testbench.sv
// Self-checking bench for the prioritized interrupt latch controller
`timescale 1ns/10ps
module testbench;
  import ipl_pkg::*;
  logic clk, rst_n, wr, rd, fte, wde, ste, boe, ftsel, wdsel, pin_en, go;
  logic acc, ret, stk_in, irq_req, trap, stk_out, me, rst_req;
  logic [7:0] addr, wdata, rdata;
  logic [31:4] mreq;
  logic [1:0] wdelay;
  logic [4:0] src;
  logic [15:0] vec;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;

  ipl_irq_ctrl i_ipl_irq_ctrl (.i_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_maskable_req(mreq), .i_fetch_trap_event(fte),
    .i_watchdog_event(wde), .i_soft_trap_event(ste), .i_bad_opcode_event(boe),
    .i_fetch_trap_action_sel(ftsel), .i_watchdog_action_sel(wdsel), .i_ext_zero_pin_enable(pin_en),
    .i_irq_accept(acc), .i_return_from_irq(ret), .i_stacked_master_enable(stk_in), .o_irq_req(irq_req),
    .o_irq_source(src), .o_irq_vector(vec), .o_trap_taken(trap), .o_stacked_master_enable(stk_out),
    .o_master_enable_flag(me), .o_reset_req(rst_req));
  ipl_cpu_model i_ipl_cpu_model (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_wait(wdelay),
    .i_irq_req(irq_req), .i_stacked_master_enable(stk_out), .o_irq_accept(acc),
    .o_return_from_irq(ret), .o_stacked_master_enable(stk_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic test_done();
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      fails++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, exp);
  endtask

  task automatic req(input logic [31:4] bits);
    @(negedge clk);
    mreq = bits;
    @(negedge clk);
    mreq = '0;
  endtask

  task automatic wait_acc(input logic [4:0] s, input logic [15:0] v, input logic st);
    int k;
    for (k = 0; k < 30 && acc !== 1'b1; k++) @(negedge clk);
    chk(acc, 1'b1);
    chk(src, s);
    chk(vec, v);
    @(negedge clk);
    chk(me, 1'b0);
    chk(stk_out, st);
    for (k = 0; k < 30 && ret !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    chk(me, st);
  endtask

  task automatic t_reset_values();
    chk(vec, VEC_RESET);
    chk(me, 1'b0);
    sfr_rd(8'h3c, 8'h00);
    sfr_rd(8'h3d, 8'h00);
    sfr_rd(8'h2e, 8'h00);
    sfr_rd(8'h2f, 8'h00);
    sfr_rd(8'h3a, 8'h00);
  endtask

  task automatic t_priority();
    sfr_wr(8'h3a, 8'hb0);
    req(28'h000000b);
    chk(irq_req, 1'b0);
    sfr_rd(8'h3c, 8'hb0);
    go = 1'b1;
    sfr_wr(8'h3a, 8'hb1);
    wait_acc(5'h04, 16'hfff6, 1'b1);
    wait_acc(5'h05, 16'hfff4, 1'b1);
    wait_acc(5'h07, 16'hfff0, 1'b1);
    go = 1'b0;
    sfr_rd(8'h3c, 8'h00);
  endtask

  task automatic t_write_clear();
    sfr_wr(8'h3a, 8'h00);
    req(28'h000000b);
    sfr_wr(8'h3c, 8'hdf);
    sfr_rd(8'h3c, 8'h90);
    sfr_wr(8'h3c, 8'hff);
    sfr_rd(8'h3c, 8'h90);
    sfr_wr(8'h3c, 8'h0c);
    sfr_rd(8'h3c, 8'h00);
    sfr_wr(8'h3c, 8'hff);
    sfr_rd(8'h3c, 8'h00);
  endtask

  task automatic t_ext_zero();
    sfr_wr(8'h3a, 8'h40);
    req(28'h0000004);
    sfr_wr(8'h3a, 8'h41);
    @(negedge clk);
    chk(irq_req, 1'b0);
    pin_en = 1'b1;
    repeat (2) @(negedge clk);
    chk(irq_req, 1'b1);
    chk(src, 5'h06);
    chk(vec, 16'hfff2);
    sfr_wr(8'h3a, 8'h00);
    sfr_wr(8'h3c, 8'h0c);
    pin_en = 1'b0;
  endtask

  task automatic t_nmi(input logic wd, input logic sel);
    ftsel = sel;
    wdsel = sel;
    @(negedge clk);
    if (wd) wde = 1'b1;
    else fte = 1'b1;
    @(negedge clk);
    wde = 1'b0;
    fte = 1'b0;
    chk(rst_req, sel);
    sfr_rd(8'h3c, sel ? 8'h00 : (wd ? 8'h08 : 8'h04));
    if (!sel) begin
      go = 1'b1;
      wait_acc(wd ? SRC_WATCHDOG : SRC_FETCH_TRAP, wd ? 16'hfff8 : 16'hfffa, 1'b0);
      go = 1'b0;
      sfr_rd(8'h3c, 8'h00);
    end
  endtask

  task automatic t_trap(input logic bad);
    sfr_wr(8'h3a, 8'h01);
    @(negedge clk);
    if (bad) boe = 1'b1;
    else ste = 1'b1;
    @(negedge clk);
    boe = 1'b0;
    ste = 1'b0;
    chk(trap, 1'b1);
    chk(vec, VEC_TRAP);
    chk(me, 1'b0);
    chk(stk_out, 1'b1);
    sfr_rd(8'h3c, 8'h00);
  endtask

  task automatic t_high_range();
    sfr_wr(8'h3a, 8'h00);
    sfr_wr(8'h2c, 8'h01);
    sfr_wr(8'h2d, 8'h80);
    sfr_wr(8'h3b, 8'h80);
    req(28'h8001800);
    sfr_rd(8'h2e, 8'h01);
    sfr_rd(8'h2f, 8'h80);
    sfr_rd(8'h3d, 8'h80);
    sfr_rd(8'h3b, 8'h80);
    wdelay = 2'h3;
    go = 1'b1;
    sfr_wr(8'h3a, 8'h01);
    wait_acc(5'h0f, 16'hffe0, 1'b1);
    wait_acc(5'h10, 16'hffbe, 1'b1);
    wait_acc(5'h1f, 16'hffa0, 1'b1);
    go = 1'b0;
    sfr_rd(8'h2f, 8'h00);
  endtask

  task automatic t_mid_reset();
    req(28'h0000020);
    sfr_rd(8'h3d, 8'h02);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    sfr_rd(8'h3d, 8'h00);
    sfr_rd(8'h2e, 8'h00);
    sfr_rd(8'h3a, 8'h00);
    sfr_rd(8'h3b, 8'h00);
  endtask

  initial begin
    rst_n = 1'b0;
    {wr, rd, fte, wde, ste, boe, pin_en, go} = '0;
    {ftsel, wdsel} = 2'h3;
    addr = 8'h00;
    wdata = 8'h00;
    mreq = '0;
    wdelay = 2'h0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_reset_values();
    t_priority();
    t_write_clear();
    t_ext_zero();
    for (int i = 0; i < 4; i++) t_nmi(i[0], i[1]);
    t_trap(1'b0);
    t_trap(1'b1);
    t_high_range();
    t_mid_reset();
    test_done();
  end
endmodule // testbench
